// File: core/bel_pkg.sv
// Purpose: shared constants and types for the bus error log
// Assumes: 64-bit registers seen as two 32-bit wishbone words
// Notes: offsets are byte addresses; address bit 2 picks the upper word
package bel_pkg;

  // register byte offsets
  localparam logic [16:0] OFF_CTRL = 17'h0_8038;
  localparam logic [16:0] OFF_ADDR = 17'h0_8040;
  localparam logic [16:0] OFF_DHI = 17'h0_8048;
  localparam logic [16:0] OFF_DLO = 17'h0_8050;
  localparam logic [16:0] OFF_ULOC = 17'h0_c008;
  localparam logic [16:0] OFF_CLOC = 17'h0_c010;
  localparam logic [16:0] OFF_USYN = 17'h1_1440;
  localparam logic [16:0] OFF_CSYN = 17'h1_1448;
  localparam logic [16:0] OFF_ENABLE = 17'h0_c100;
  localparam logic [16:0] OFF_STATUS = 17'h0_c108;

  // control capture layout: tid[5:0], mid[8:6], ctl_par[9], par[13:10]
  localparam int CTL_W = 14;
  localparam int CTRL_A_LSB = 32;
  localparam int CTRL_D_LSB = 0;

  // location log layout
  localparam int LOC_ADDR_W = 30;
  localparam int LOC_TID_LSB = 32;
  localparam int LOC_MID_LSB = 38;

  localparam logic [63:0] LOC_RST = 64'h0000_0000_3fff_ffff;
  localparam logic [63:0] SYN_RST = 64'h0000_0000_0000_0000;
  localparam logic [63:0] CAP_RST = 64'h0000_0000_0000_0000;

  localparam logic [2:0] MID_BCAST = 3'h7;
  localparam logic [2:0] MID_IOC = 3'h6;
  localparam logic [1:0] TID_CACHE = 2'h0;
  localparam logic [1:0] TID_XLATE = 2'h2;
  localparam logic [1:0] TID_PEER = 2'h1;
  localparam logic [1:0] TID_NMWR = 2'h3;

  // enable and status bit positions
  localparam int EN_BUS = 0;
  localparam int EN_COR = 1;
  localparam int EN_UNC = 2;
  localparam int EN_SIG = 3;
  localparam logic [3:0] EN_RST = 4'h0;
  localparam int ST_FRZ = 0;
  localparam int ST_UNC = 1;
  localparam int ST_COR = 2;
  localparam int ST_BC = 3;

  localparam int SB_W = 144;

  typedef enum logic [1:0] {IOC_CACHE, IOC_XLATE, IOC_PEER, IOC_NMWR} bel_ioc_src_e;
  typedef enum {BC_IDLE, BC_REQ, BC_DONE} bel_bcast_e;

  function automatic logic [1:0] tid_hi(input bel_ioc_src_e s);
    case (s)
      IOC_CACHE: tid_hi = TID_CACHE;
      IOC_XLATE: tid_hi = TID_XLATE;
      IOC_PEER: tid_hi = TID_PEER;
      default: tid_hi = TID_NMWR;
    endcase
  endfunction

  function automatic logic [63:0] loc_word(input logic [2:0] mid, input logic [5:0] tid,
                                           input logic [29:0] line);
    loc_word = '0;
    loc_word[LOC_MID_LSB +: 3] = mid;
    loc_word[LOC_TID_LSB +: 6] = tid;
    loc_word[LOC_ADDR_W-1:0] = line;
  endfunction

endpackage

// File: core/bel_bcast_if.sv
// Purpose: links the log core to the broadcast-error issuer
// Assumes: single clock
// Notes: trig and clr are one-cycle pulses
`timescale 1ns/10ps
interface bel_bcast_if;
  logic trig;
  logic clr;
  logic gnt;
  logic req;
  logic blocked;
  modport core (input trig, input clr, input gnt, output req, output blocked);
  modport ctl (output trig, output clr, output gnt, input req, input blocked);
endinterface

// File: core/bel_bcast.sv
// Purpose: issues one broadcast-error transaction per uncleared error
// Assumes: grant comes from on-chip arbitration on the same clock
// Notes: only broadcast errors exist here; directed errors are never made
`timescale 1ns/10ps
module bel_bcast (
  input wire logic clk_i,
  input wire logic rst_i,
  bel_bcast_if.core bc
);

  bel_pkg::bel_bcast_e state_ff;
  bel_pkg::bel_bcast_e nxt_state;

  // a new error in the clearing cycle re-arms at once, so it is not lost
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      bel_pkg::BC_IDLE: begin
        if (bc.trig) nxt_state = bel_pkg::BC_REQ;
      end
      bel_pkg::BC_REQ: begin
        if (bc.gnt) nxt_state = bel_pkg::BC_DONE;
      end
      bel_pkg::BC_DONE: begin
        if (bc.trig && bc.clr) nxt_state = bel_pkg::BC_REQ;
        else if (bc.clr) nxt_state = bel_pkg::BC_IDLE;
      end
      default: nxt_state = bel_pkg::BC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) state_ff <= bel_pkg::BC_IDLE;
    else state_ff <= nxt_state;
  end

  // the only error request type driven out is broadcast
  assign bc.req = (state_ff == bel_pkg::BC_REQ);
  assign bc.blocked = (state_ff != bel_pkg::BC_IDLE);

endmodule

// File: core/bel_top.sv
// Purpose: system bus capture and memory error logs, read over wishbone
// Assumes: one 20 MHz clock; system bus pins are synchronised here
// Notes: each 64-bit log is two words, low word at the lower address
// Functional notes
// - control capture: address-cycle fields in upper half, data-cycle in lower
// - control capture reloads each non-idle cycle, holds once an error is seen
// - broadcast errors we issue carry requester tag 7
// - io_controller transactions carry requester tag 6
// - io_controller transaction tag top bits: 00 cache, 10 translate, 01 peer, 11 write
// - address capture loads lower 64 bus bits per address cycle, freezes on error
// - upper data capture loads upper 64 data bits per data cycle, freezes on error
// - lower data capture loads lower 64 data bits per data cycle, freezes on error
// - uncorrectable log keeps requester, transaction tag, line address; updates only then
// - correctable log keeps requester, transaction tag, address; updates only then
// - location log address bits reset to all ones
// - uncorrectable syndrome: one byte per word, byte N from word N
// - correctable syndrome stored with the same byte-per-word order
// - syndrome logs reset to zero and change only on their error
// - uncorrectable read served cache-to-cache raises a broadcast error
// - no directed-error transaction is ever issued
// - one broadcast per error until software clears it
// - correctable checking and logging run only while its enable is set
// - an error sets status and freezes logs only when its log enable is set
`timescale 1ns/10ps
module bel_top (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // system bus observation pins
  input wire logic sb_addr_cyc_i,
  input wire logic sb_data_cyc_i,
  input wire logic [127:0] sb_ad_i,
  input wire logic [5:0] sb_tid_i,
  input wire logic [2:0] sb_mid_i,
  input wire logic sb_ctl_par_i,
  input wire logic [3:0] sb_ad_par_i,
  // error events from on-chip checkers
  input wire logic bus_err_i,
  input wire logic mem_unc_err_i,
  input wire logic mem_cor_err_i,
  input wire logic mem_c2c_hit_i,
  input wire logic [2:0] mem_mid_i,
  input wire logic [5:0] mem_tid_i,
  input wire logic [29:0] mem_line_i,
  input wire logic [63:0] uncorr_err_syndrome_i,
  // broadcast error issue
  input wire logic bcast_gnt_i,
  output logic bcast_req_o,
  output logic [2:0] bcast_mid_o,
  // io_controller tag generation
  input wire bel_pkg::bel_ioc_src_e ioc_src_i,
  input wire logic [3:0] ioc_tid_lo_i,
  output logic [2:0] ioc_mid_o,
  output logic [5:0] ioc_tid_o,
  output logic corr_chk_en_o
);

  logic [bel_pkg::SB_W-1:0] sb_s1_ff;
  logic [bel_pkg::SB_W-1:0] sb_s2_ff;
  logic s_acyc;
  logic s_dcyc;
  logic [127:0] s_ad;
  logic [5:0] s_tid;
  logic [2:0] s_mid;
  logic s_cpar;
  logic [3:0] s_apar;
  logic [bel_pkg::CTL_W-1:0] ctl_w;

  logic [63:0] ctrl_ff;
  logic [63:0] addr_ff;
  logic [63:0] dhi_ff;
  logic [63:0] dlo_ff;
  logic [63:0] uloc_ff;
  logic [63:0] usyn_ff;
  logic [63:0] cloc_ff;
  logic [63:0] csyn_ff;
  logic [3:0] en_ff;
  logic frz_ff;
  logic ustat_ff;
  logic cstat_ff;
  logic [5:0] ioc_tid_ff;

  logic ack_ff;
  logic [31:0] dat_ff;
  logic req_w;
  logic wr_w;
  logic in_rng_w;
  logic st_wr_w;
  logic [63:0] rd64;
  logic [3:0] st_w;

  logic bus_ev;
  logic unc_ev;
  logic cor_ev;
  logic bc_trig_w;
  logic bc_clr_w;

  bel_bcast_if bc_if ();

  // ---------------- pin synchronisers
  // wide but cheap: capture values are only ever read after the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sb_s1_ff <= '0;
      sb_s2_ff <= '0;
    end else begin
      sb_s1_ff <= {sb_addr_cyc_i, sb_data_cyc_i, sb_ad_i, sb_tid_i, sb_mid_i,
                   sb_ctl_par_i, sb_ad_par_i};
      sb_s2_ff <= sb_s1_ff;
    end
  end

  assign {s_acyc, s_dcyc, s_ad, s_tid, s_mid, s_cpar, s_apar} = sb_s2_ff;
  assign ctl_w = {s_apar, s_cpar, s_mid, s_tid};

  // ---------------- error events, gated by their log enables
  assign bus_ev = bus_err_i && en_ff[bel_pkg::EN_BUS];
  assign unc_ev = mem_unc_err_i && en_ff[bel_pkg::EN_UNC];
  assign cor_ev = mem_cor_err_i && en_ff[bel_pkg::EN_COR];
  assign corr_chk_en_o = en_ff[bel_pkg::EN_COR];

  // ---------------- bus capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= bel_pkg::CAP_RST;
      addr_ff <= bel_pkg::CAP_RST;
    end else if (!frz_ff) begin
      if (s_acyc) begin
        ctrl_ff[bel_pkg::CTRL_A_LSB +: bel_pkg::CTL_W] <= ctl_w;
        addr_ff <= s_ad[63:0];
      end
      if (s_dcyc) begin
        ctrl_ff[bel_pkg::CTRL_D_LSB +: bel_pkg::CTL_W] <= ctl_w;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dhi_ff <= bel_pkg::CAP_RST;
      dlo_ff <= bel_pkg::CAP_RST;
    end else if (!frz_ff && s_dcyc) begin
      dhi_ff <= s_ad[127:64];
      dlo_ff <= s_ad[63:0];
    end
  end

  // freeze: a new error in the clearing cycle keeps it set
  always_ff @(posedge clk_i) begin
    if (rst_i) frz_ff <= 1'b0;
    else if (bus_ev) frz_ff <= 1'b1;
    else if (st_wr_w && wb_dat_i[bel_pkg::ST_FRZ]) frz_ff <= 1'b0;
  end

  // ---------------- uncorrectable log, first error wins until cleared
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uloc_ff <= bel_pkg::LOC_RST;
      usyn_ff <= bel_pkg::SYN_RST;
    end else if (unc_ev && !ustat_ff) begin
      uloc_ff <= bel_pkg::loc_word(mem_mid_i, mem_tid_i, mem_line_i);
      usyn_ff <= uncorr_err_syndrome_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) ustat_ff <= 1'b0;
    else if (unc_ev) ustat_ff <= 1'b1;
    else if (st_wr_w && wb_dat_i[bel_pkg::ST_UNC]) ustat_ff <= 1'b0;
  end

  // ---------------- correctable log
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cloc_ff <= bel_pkg::LOC_RST;
      csyn_ff <= bel_pkg::SYN_RST;
    end else if (cor_ev && !cstat_ff) begin
      cloc_ff <= bel_pkg::loc_word(mem_mid_i, mem_tid_i, mem_line_i);
      csyn_ff <= uncorr_err_syndrome_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) cstat_ff <= 1'b0;
    else if (cor_ev) cstat_ff <= 1'b1;
    else if (st_wr_w && wb_dat_i[bel_pkg::ST_COR]) cstat_ff <= 1'b0;
  end

  // ---------------- broadcast error issue
  // a cache-to-cache hit leaves no path to flag bad data, so broadcast instead
  assign bc_trig_w = en_ff[bel_pkg::EN_SIG] &&
                     (bus_ev || (unc_ev && mem_c2c_hit_i));
  assign bc_clr_w = st_wr_w && wb_dat_i[bel_pkg::ST_BC];

  assign bc_if.trig = bc_trig_w;
  assign bc_if.clr = bc_clr_w;
  assign bc_if.gnt = bcast_gnt_i;

  bel_bcast bel_bcast_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bc(bc_if.core)
  );

  assign bcast_req_o = bc_if.req;
  assign bcast_mid_o = bel_pkg::MID_BCAST;

  // ---------------- io_controller tags
  always_ff @(posedge clk_i) begin
    if (rst_i) ioc_tid_ff <= 6'h00;
    else ioc_tid_ff <= {bel_pkg::tid_hi(ioc_src_i), ioc_tid_lo_i};
  end

  assign ioc_tid_o = ioc_tid_ff;
  assign ioc_mid_o = bel_pkg::MID_IOC;

  // ---------------- wishbone slave, ack one cycle after the strobe
  assign req_w = wb_cyc_i && wb_stb_i && !ack_ff;
  assign in_rng_w = (wb_adr_i[31:17] == 15'h0000);
  // writes land on the edge at which the master samples ack, never a cycle early
  assign wr_w = wb_cyc_i && wb_stb_i && ack_ff && wb_we_i && in_rng_w;
  assign st_wr_w = wr_w && wb_sel_i[0] && (wb_adr_i[16:2] == bel_pkg::OFF_STATUS[16:2]);
  assign st_w = {bc_if.blocked, cstat_ff, ustat_ff, frz_ff};

  always_comb begin
    rd64 = 64'h0000_0000_0000_0000;
    if (in_rng_w) begin
      case (wb_adr_i[16:3])
        bel_pkg::OFF_CTRL[16:3]: rd64 = ctrl_ff;
        bel_pkg::OFF_ADDR[16:3]: rd64 = addr_ff;
        bel_pkg::OFF_DHI[16:3]: rd64 = dhi_ff;
        bel_pkg::OFF_DLO[16:3]: rd64 = dlo_ff;
        bel_pkg::OFF_ULOC[16:3]: rd64 = uloc_ff;
        bel_pkg::OFF_USYN[16:3]: rd64 = usyn_ff;
        bel_pkg::OFF_CLOC[16:3]: rd64 = cloc_ff;
        bel_pkg::OFF_CSYN[16:3]: rd64 = csyn_ff;
        bel_pkg::OFF_ENABLE[16:3]: rd64 = {60'h0, en_ff};
        bel_pkg::OFF_STATUS[16:3]: rd64 = {60'h0, st_w};
        default: rd64 = 64'h0000_0000_0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) ack_ff <= 1'b0;
    else ack_ff <= req_w;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) dat_ff <= 32'h0000_0000;
    else if (req_w && !wb_we_i) dat_ff <= wb_adr_i[2] ? rd64[63:32] : rd64[31:0];
  end

  // only the enable and status words take writes; logs ignore them
  always_ff @(posedge clk_i) begin
    if (rst_i) en_ff <= bel_pkg::EN_RST;
    else if (wr_w && wb_sel_i[0] && wb_adr_i[16:2] == bel_pkg::OFF_ENABLE[16:2])
      en_ff <= wb_dat_i[3:0];
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // ---------------- assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_acap;
    s_acyc && !frz_ff;
  endsequence

  sequence s_cfirst;
    cor_ev && !cstat_ff;
  endsequence

  sequence s_sent;
    bcast_req_o && bcast_gnt_i;
  endsequence

  sequence s_dcap;
    s_dcyc && !frz_ff;
  endsequence

  a_ctrl_addr_half:
    assert property (s_acap |=> ctrl_ff[bel_pkg::CTRL_A_LSB +: bel_pkg::CTL_W] == $past(ctl_w))
    else $error("address half of control capture not loaded");

  a_ctrl_freeze:
    assert property (frz_ff |=> $stable(ctrl_ff) && $stable(dlo_ff))
    else $error("bus capture changed while frozen");

  a_bcast_tag:
    assert property (bcast_req_o && !bcast_gnt_i |=> bcast_req_o &&
                     bcast_mid_o == bel_pkg::MID_BCAST)
    else $error("broadcast request with wrong requester tag");

  a_ioc_tag_bits:
    assert property (1'b1 |=> ioc_tid_o[5:4] == bel_pkg::tid_hi($past(ioc_src_i)) &&
                     ioc_mid_o == bel_pkg::MID_IOC)
    else $error("io controller tag encoding wrong");

  a_addr_load:
    assert property (s_acap |=> addr_ff == $past(s_ad[63:0]))
    else $error("address capture not loaded");

  a_unc_hold:
    assert property (!(unc_ev && !ustat_ff) |=> $stable(uloc_ff) && $stable(usyn_ff))
    else $error("uncorrectable log changed without an error");

  a_cor_load:
    assert property (s_cfirst |=> cstat_ff && csyn_ff == $past(uncorr_err_syndrome_i) &&
                     cloc_ff[29:0] == $past(mem_line_i))
    else $error("correctable log not loaded");

  a_bcast_once:
    assert property ((s_sent ##1 (!bc_clr_w) [*2]) |=> !bcast_req_o)
    else $error("second broadcast before clear");

  a_data_load:
    assert property (s_dcap |=> dhi_ff == $past(s_ad[127:64]) &&
                     dlo_ff == $past(s_ad[63:0]) &&
                     ctrl_ff[bel_pkg::CTRL_D_LSB +: bel_pkg::CTL_W] == $past(ctl_w))
    else $error("data capture not loaded");

  a_unc_load:
    assert property (unc_ev && !ustat_ff |=> ustat_ff && usyn_ff == $past(uncorr_err_syndrome_i) &&
                     uloc_ff[bel_pkg::LOC_TID_LSB +: 6] == $past(mem_tid_i) &&
                     uloc_ff[29:0] == $past(mem_line_i))
    else $error("uncorrectable log not loaded");

  a_cor_hold:
    assert property (!(cor_ev && !cstat_ff) |=> $stable(cloc_ff) && $stable(csyn_ff))
    else $error("correctable log changed without an error");

  a_cor_gate:
    assert property (mem_cor_err_i && !en_ff[bel_pkg::EN_COR] && !cstat_ff |=> !cstat_ff)
    else $error("correctable status set while its enable is clear");

  a_freeze_set:
    assert property (bus_ev |=> frz_ff)
    else $error("bus error did not freeze the captures");

  a_bcast_trig:
    assert property (bc_trig_w && !bc_if.blocked |=> bcast_req_o)
    else $error("broadcast not requested after its trigger");

  a_ack_pulse:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("wishbone ack held longer than one cycle");

endmodule

// File: tb/bel_sbus_model.sv
// Purpose: far-side bus agent, drives observation pins and grants broadcasts
// Assumes: shares the core clock with the log block
// Notes: released pins other than the cycle flags carry the inverse of the last value, never a stale copy; the cycle flags drop to 0
`timescale 1ns/10ps
module bel_sbus_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bcast_req_i,
  input wire logic [3:0] gnt_dly_i,
  output logic sb_addr_cyc_o,
  output logic sb_data_cyc_o,
  output logic [127:0] sb_ad_o,
  output logic [5:0] sb_tid_o,
  output logic [2:0] sb_mid_o,
  output logic sb_ctl_par_o,
  output logic [3:0] sb_ad_par_o,
  output logic bcast_gnt_o
);
  logic [3:0] wait_cnt;

  initial begin
    {sb_addr_cyc_o, sb_data_cyc_o, sb_ad_o, sb_tid_o} = '0;
    {sb_mid_o, sb_ctl_par_o, sb_ad_par_o, bcast_gnt_o, wait_cnt} = '0;
  end

  // one bus cycle, then one idle cycle so back-to-back calls never collide
  task automatic put(input logic a, input logic d, input logic [127:0] ad,
                     input logic [5:0] tid, input logic [2:0] mid, input logic cp,
                     input logic [3:0] ap);
    sb_addr_cyc_o <= a;
    sb_data_cyc_o <= d;
    sb_ad_o <= ad;
    sb_tid_o <= tid;
    sb_mid_o <= mid;
    sb_ctl_par_o <= cp;
    sb_ad_par_o <= ap;
    @(posedge clk_i);
    sb_addr_cyc_o <= 1'b0;
    sb_data_cyc_o <= 1'b0;
    sb_ad_o <= ~ad;
    sb_tid_o <= ~tid;
    sb_mid_o <= ~mid;
    sb_ctl_par_o <= ~cp;
    sb_ad_par_o <= ~ap;
    @(posedge clk_i);
  endtask

  // arbiter: grant after gnt_dly_i waiting cycles, for one cycle only
  always @(posedge clk_i) begin
    if (rst_i || !bcast_req_i || bcast_gnt_o) begin
      wait_cnt <= 4'h0;
      bcast_gnt_o <= 1'b0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
      bcast_gnt_o <= (wait_cnt >= gnt_dly_i);
    end
  end
endmodule

// File: tb/bel_top_tb.sv
// Purpose: self-checking bench for the bus error log
// Assumes: wishbone ack one cycle after the request edge
// Notes: capture checks wait the fixed synchroniser depth plus margin
`timescale 1ns/10ps
module bel_top_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
  logic [3:0] wb_sel_i, sb_ad_par_i, ioc_tid_lo_i, gnt_dly;
  logic sb_addr_cyc_i, sb_data_cyc_i, sb_ctl_par_i, bus_err_i, mem_unc_err_i;
  logic mem_cor_err_i, mem_c2c_hit_i, bcast_gnt_i, bcast_req_o, corr_chk_en_o;
  logic [127:0] sb_ad_i;
  logic [5:0] sb_tid_i, mem_tid_i, ioc_tid_o;
  logic [2:0] sb_mid_i, mem_mid_i, bcast_mid_o, ioc_mid_o;
  logic [29:0] mem_line_i;
  logic [63:0] uncorr_err_syndrome_i;
  bel_pkg::bel_ioc_src_e ioc_src_i;
  int fail_count = 0;
  int comparisons = 0;
  int bc_count = 0;
  localparam logic [127:0] AD0 = 128'h0000_0000_0000_0000_8765_4321_0fed_cba9;
  localparam logic [127:0] AD1 = 128'hdead_beef_0bad_f00d_cafe_0123_4567_89ab;

  bel_top bel_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sb_addr_cyc_i(sb_addr_cyc_i),
    .sb_data_cyc_i(sb_data_cyc_i), .sb_ad_i(sb_ad_i), .sb_tid_i(sb_tid_i),
    .sb_mid_i(sb_mid_i), .sb_ctl_par_i(sb_ctl_par_i), .sb_ad_par_i(sb_ad_par_i),
    .bus_err_i(bus_err_i), .mem_unc_err_i(mem_unc_err_i), .mem_cor_err_i(mem_cor_err_i),
    .mem_c2c_hit_i(mem_c2c_hit_i), .mem_mid_i(mem_mid_i), .mem_tid_i(mem_tid_i),
    .mem_line_i(mem_line_i), .uncorr_err_syndrome_i(uncorr_err_syndrome_i), .bcast_gnt_i(bcast_gnt_i),
    .bcast_req_o(bcast_req_o), .bcast_mid_o(bcast_mid_o), .ioc_src_i(ioc_src_i),
    .ioc_tid_lo_i(ioc_tid_lo_i), .ioc_mid_o(ioc_mid_o), .ioc_tid_o(ioc_tid_o),
    .corr_chk_en_o(corr_chk_en_o));

  bel_sbus_model bel_sbus_model_i (.clk_i(clk_i), .rst_i(rst_i), .bcast_req_i(bcast_req_o),
    .gnt_dly_i(gnt_dly), .sb_addr_cyc_o(sb_addr_cyc_i), .sb_data_cyc_o(sb_data_cyc_i),
    .sb_ad_o(sb_ad_i), .sb_tid_o(sb_tid_i), .sb_mid_o(sb_mid_i),
    .sb_ctl_par_o(sb_ctl_par_i), .sb_ad_par_o(sb_ad_par_i), .bcast_gnt_o(bcast_gnt_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic complete_run;
    $display("fail_count %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic we, input logic [31:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      complete_run();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [16:0] off, input logic [31:0] wd);
    logic [31:0] d;
    xfer(1'b1, {15'h0, off}, wd, d);
  endtask

  task automatic rd64(input logic [16:0] off, output logic [63:0] v);
    xfer(1'b0, {15'h0, off}, 32'h0, v[31:0]);
    xfer(1'b0, {15'h0, off} + 32'h0000_0004, 32'h0, v[63:32]);
  endtask

  task automatic pulse(input logic b, input logic u, input logic c, input logic h,
                       input logic [2:0] mid, input logic [5:0] tid, input logic [29:0] ln,
                       input logic [63:0] syn);
    {bus_err_i, mem_unc_err_i, mem_cor_err_i, mem_c2c_hit_i} <= {b, u, c, h};
    {mem_mid_i, mem_tid_i, mem_line_i, uncorr_err_syndrome_i} <= {mid, tid, ln, syn};
    @(posedge clk_i);
    {bus_err_i, mem_unc_err_i, mem_cor_err_i, mem_c2c_hit_i} <= 4'h0;
    {mem_mid_i, mem_tid_i, mem_line_i, uncorr_err_syndrome_i} <= ~{mid, tid, ln, syn};
    @(posedge clk_i);
  endtask

  task automatic wait_bc(input int n);
    int k;
    for (k = 0; k < 40 && bc_count < n; k++) @(posedge clk_i);
    chk(bc_count, n);
  endtask

  // a broadcast is counted when the arbiter grants it
  always @(posedge clk_i) begin
    if (bcast_req_o === 1'b1 && bcast_gnt_i === 1'b1) begin
      bc_count <= bc_count + 1;
      chk(bcast_mid_o, 3'h7);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end

  initial begin
    logic [16:0] offs [8];
    logic [63:0] rsts [8];
    logic [1:0] codes [4];
    logic [63:0] v;
    logic [63:0] cloc;
    int i;
    offs = '{bel_pkg::OFF_CTRL, bel_pkg::OFF_ADDR, bel_pkg::OFF_DHI, bel_pkg::OFF_DLO,
             bel_pkg::OFF_ULOC, bel_pkg::OFF_CLOC, bel_pkg::OFF_USYN, bel_pkg::OFF_CSYN};
    rsts = '{64'h0, 64'h0, 64'h0, 64'h0, 64'h0000_0000_3fff_ffff, 64'h0000_0000_3fff_ffff,
             64'h0, 64'h0};
    codes = '{2'h0, 2'h2, 2'h1, 2'h3};
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    {bus_err_i, mem_unc_err_i, mem_cor_err_i, mem_c2c_hit_i} = 4'h0;
    {mem_mid_i, mem_tid_i, mem_line_i, uncorr_err_syndrome_i} = '0;
    ioc_src_i = bel_pkg::IOC_CACHE;
    ioc_tid_lo_i = 4'h0;
    gnt_dly = 4'h0;
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 8; i++) begin
      rd64(offs[i], v);
      chk(v, rsts[i]);
    end
    rd64(17'h0_7ff0, v);
    chk(v, 64'h0);
    wr(bel_pkg::OFF_ULOC, 32'hffff_ffff);
    rd64(bel_pkg::OFF_ULOC, v);
    chk(v, 64'h0000_0000_3fff_ffff);
    wr(bel_pkg::OFF_ENABLE, 32'h0000_000f);
    chk(corr_chk_en_o, 1'b1);
    for (i = 0; i < 4; i++) begin
      ioc_src_i <= bel_pkg::bel_ioc_src_e'(i);
      ioc_tid_lo_i <= 4'(i + 5);
      repeat (2) @(posedge clk_i);
      chk(ioc_mid_o, 3'h6);
      chk(ioc_tid_o, {codes[i], 4'(i + 5)});
    end
    bel_sbus_model_i.put(1'b1, 1'b0, AD0, 6'h2a, 3'h5, 1'b1, 4'h9);
    bel_sbus_model_i.put(1'b0, 1'b1, AD1, 6'h15, 3'h3, 1'b0, 4'h6);
    repeat (4) @(posedge clk_i);
    rd64(bel_pkg::OFF_CTRL, v);
    chk(v, {18'h0, 4'h9, 1'b1, 3'h5, 6'h2a, 18'h0, 4'h6, 1'b0, 3'h3, 6'h15});
    rd64(bel_pkg::OFF_ADDR, v);
    chk(v, AD0[63:0]);
    rd64(bel_pkg::OFF_DHI, v);
    chk(v, AD1[127:64]);
    rd64(bel_pkg::OFF_DLO, v);
    chk(v, AD1[63:0]);
    pulse(1'b0, 1'b1, 1'b0, 1'b0, 3'h4, 6'h31, 30'h0123_4567, 64'h8877_6655_4433_2211);
    rd64(bel_pkg::OFF_ULOC, v);
    chk(v, {23'h0, 3'h4, 6'h31, 2'h0, 30'h0123_4567});
    rd64(bel_pkg::OFF_USYN, v);
    chk(v, 64'h8877_6655_4433_2211);
    rd64(bel_pkg::OFF_CSYN, v);
    chk(v, 64'h0);
    cloc = {23'h0, 3'h2, 6'h0c, 2'h0, 30'h3fff_0000};
    pulse(1'b0, 1'b0, 1'b1, 1'b0, 3'h2, 6'h0c, 30'h3fff_0000, 64'h0102_0304_0506_0708);
    rd64(bel_pkg::OFF_CLOC, v);
    chk(v, cloc);
    rd64(bel_pkg::OFF_CSYN, v);
    chk(v, 64'h0102_0304_0506_0708);
    chk(bc_count, 0);
    gnt_dly <= 4'h3;
    pulse(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 6'h0, 30'h0, 64'h0);
    wait_bc(1);
    bel_sbus_model_i.put(1'b1, 1'b0, AD1, 6'h01, 3'h1, 1'b0, 4'h1);
    repeat (4) @(posedge clk_i);
    rd64(bel_pkg::OFF_ADDR, v);
    chk(v, AD0[63:0]);
    pulse(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 6'h0, 30'h0, 64'h0);
    repeat (10) @(posedge clk_i);
    chk(bc_count, 1);
    wr(bel_pkg::OFF_STATUS, 32'h0000_000f);
    bel_sbus_model_i.put(1'b1, 1'b0, AD1, 6'h01, 3'h1, 1'b0, 4'h1);
    repeat (4) @(posedge clk_i);
    rd64(bel_pkg::OFF_ADDR, v);
    chk(v, AD1[63:0]);
    pulse(1'b0, 1'b1, 1'b0, 1'b1, 3'h1, 6'h02, 30'h0000_0040, 64'h0);
    wait_bc(2);
    wr(bel_pkg::OFF_ENABLE, 32'h0);
    chk(corr_chk_en_o, 1'b0);
    wr(bel_pkg::OFF_STATUS, 32'h0000_000f);
    pulse(1'b1, 1'b0, 1'b1, 1'b0, 3'h6, 6'h3f, 30'h0000_1111, 64'hffff_0000_ffff_0000);
    rd64(bel_pkg::OFF_STATUS, v);
    chk(v, 64'h0);
    rd64(bel_pkg::OFF_CLOC, v);
    chk(v, cloc);
    // mid-run reset must bring every capture and log back to its reset value
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 8; i++) begin
      rd64(offs[i], v);
      chk(v, rsts[i]);
    end
    complete_run();
  end
endmodule
